//--- pgbl_pkg.sv
// types and constants for the pixel gain and black-level stage
package pgbl_pkg;

  localparam int PGBL_PIX_W = 12;
  localparam int PGBL_CODE_W = 10;
  localparam int PGBL_MANT_W = 12;
  localparam int PGBL_PROD_W = 24;

  // sensor variant: gain law and black-level range go together per variant
  typedef enum logic [1:0] {
    PGBL_VAR_DEFAULT,
    PGBL_VAR_LOW,
    PGBL_VAR_WIDE_LOG,
    PGBL_VAR_WIDE_LINEAR
  } pgbl_variant_t;

  typedef enum logic {
    PGBL_DEPTH_8,
    PGBL_DEPTH_12
  } pgbl_depth_t;

  typedef struct packed {
    logic valid;
    logic [11:0] data;
  } pgbl_pix_t;

  typedef struct packed {
    logic [PGBL_CODE_W-1:0] gain_code;
    logic [PGBL_CODE_W-1:0] black_code;
    logic reject;
    logic s1_valid;
    logic [PGBL_PROD_W-1:0] s1_prod;
    logic [2:0] s1_shift;
    logic [PGBL_CODE_W-1:0] s1_offset;
    logic s1_depth8;
    pgbl_pix_t out;
  } pgbl_state_t;

  // accepted code ranges
  localparam logic [9:0] PGBL_GAIN_MAX_LOW = 10'h016;
  localparam logic [9:0] PGBL_GAIN_MAX_FULL = 10'h3FF;
  localparam logic [9:0] PGBL_BLACK_MAX_DEFAULT = 10'h0FF;
  localparam logic [9:0] PGBL_BLACK_MAX_LOW = 10'h040;
  localparam logic [9:0] PGBL_BLACK_MAX_WIDE = 10'h3FF;

  // reset values
  localparam logic [9:0] PGBL_GAIN_RESET = 10'h000;
  localparam logic [9:0] PGBL_BLACK_RESET = 10'h000;

  // black-level code steps per output count, as right shifts
  localparam logic [2:0] PGBL_BL_SH_DEF8 = 3'h4;
  localparam logic [2:0] PGBL_BL_SH_DEF12 = 3'h0;
  localparam logic [2:0] PGBL_BL_SH_LOW = 3'h2;
  localparam logic [2:0] PGBL_BL_SH_WIDE8 = 3'h6;
  localparam logic [2:0] PGBL_BL_SH_WIDE12 = 3'h2;

  // gain mantissa is Q8: unity is 256
  localparam logic [11:0] PGBL_UNITY = 12'h100;
  localparam logic [15:0] PGBL_LOW_DIV = 16'h0006;
  localparam logic [15:0] PGBL_LOW_BIAS = 16'h0006;
  // linear law: log2 gain in Q8 = code*391/256 - 229 (0.0359 dB/code, -5.385 dB)
  localparam logic [8:0] PGBL_LIN_SLOPE = 9'h187;
  localparam logic [10:0] PGBL_LIN_OFFS = 11'h0E5;
  // 2^(k/16) in Q8 for k = 0..16
  localparam logic [9:0] PGBL_EXP_LUT [0:16] = '{
    10'h100, 10'h10B, 10'h117, 10'h124, 10'h130, 10'h13E, 10'h14C, 10'h15B, 10'h16A,
    10'h17A, 10'h18B, 10'h19C, 10'h1AF, 10'h1C1, 10'h1D6, 10'h1EA, 10'h200};

  localparam logic [11:0] PGBL_MAX12 = 12'hFFF;
  localparam logic [11:0] PGBL_MAX8 = 12'h0FF;
  localparam logic [3:0] PGBL_DEPTH_SHIFT = 4'h4;

endpackage

//--- pgbl_core.sv
// pixel gain and black-level conditioning stage
// How it works
// R1 - on the low-range variant a gain code is taken only from 0 to 22.
// R2 - on the low-range variant the pixel is multiplied by one plus the gain code over six.
// R3 - on the linear-law variant the gain in dB is 0.0359 times the code minus 5.385; the code holds 0 dB for codes 0 to 150.
// R4 - a higher black-level code adds a larger offset, a lower one a smaller offset.
// R5 - default variants in 8 bit depth shift the output one count per 16 code steps.
// R6 - default variants in 12 bit depth shift the output one count per code step.
// R7 - the low-range variant shifts the output one count per 4 code steps in any depth.
// R8 - wide-range variants in 8 bit depth shift the output one count per 64 code steps.
// R9 - wide-range variants in 12 bit depth shift the output one count per 4 code steps.
// R10 - default variants take black-level codes from 0 to 255.
// R11 - the low-range variant takes black-level codes from 0 to 64.
// R12 - wide-range variants take black-level codes from 0 to 1023.
// R13 - software points the gain selector at all channels before writing the gain code.
// R14 - software points the black-level selector at all channels before writing its code.
// R15 - the lowest permitted gain code gives exactly 0 dB on every variant.
// R16 - the result is clamped to the output depth instead of wrapping.
`timescale 1ns/1ps
module pgbl_core (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire pgbl_pkg::pgbl_variant_t VARIANT,
  input wire pgbl_pkg::pgbl_depth_t DEPTH,
  input wire logic GAIN_SEL_ALL,
  input wire logic GAIN_WR,
  input wire logic [9:0] GAIN_CODE,
  input wire logic BLACK_SEL_ALL,
  input wire logic BLACK_WR,
  input wire logic [9:0] BLACK_CODE,
  input wire pgbl_pkg::pgbl_pix_t PIX_IN,
  output pgbl_pkg::pgbl_pix_t PIX_OUT,
  output logic [9:0] GAIN_NOW,
  output logic [9:0] BLACK_NOW,
  output logic CODE_REJECT
);
  import pgbl_pkg::*;

  pgbl_state_t s_reg;
  pgbl_state_t s_next;

  logic [9:0] gain_max;
  logic [9:0] black_max;
  logic [2:0] bl_shift;
  logic [11:0] mant;
  logic [2:0] gshift;
  logic [15:0] low_num;
  logic [15:0] low_q;
  logic [18:0] lin_prod;
  logic [10:0] lin_log;
  logic [10:0] lin_pos;
  logic [3:0] lut_k;
  logic [3:0] lut_lo;
  logic [9:0] lut_a;
  logic [9:0] lut_b;
  logic [13:0] lut_step;
  logic [28:0] scaled;
  logic [20:0] gained;
  logic [11:0] gained12;
  logic [11:0] base;
  logic [12:0] sum;
  logic [11:0] out_max;

  //////////////////////////////////////////////////////////////////////////////
  // per-variant limits and black-level step size
  always_comb begin
    gain_max = PGBL_GAIN_MAX_FULL;
    black_max = PGBL_BLACK_MAX_DEFAULT;
    bl_shift = PGBL_BL_SH_DEF12;
    unique case (VARIANT)
      PGBL_VAR_DEFAULT: begin
        // R10 default black range
        black_max = PGBL_BLACK_MAX_DEFAULT;
        // R5 R6 default step size
        bl_shift = (DEPTH == PGBL_DEPTH_8) ? PGBL_BL_SH_DEF8 : PGBL_BL_SH_DEF12;
      end
      PGBL_VAR_LOW: begin
        // R1 low gain range
        gain_max = PGBL_GAIN_MAX_LOW;
        // R11 low black range
        black_max = PGBL_BLACK_MAX_LOW;
        // R7 four steps per count
        bl_shift = PGBL_BL_SH_LOW;
      end
      PGBL_VAR_WIDE_LOG, PGBL_VAR_WIDE_LINEAR: begin
        // R12 wide black range
        black_max = PGBL_BLACK_MAX_WIDE;
        // R8 R9 wide step size
        bl_shift = (DEPTH == PGBL_DEPTH_8) ? PGBL_BL_SH_WIDE8 : PGBL_BL_SH_WIDE12;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // gain code to Q8 mantissa and power-of-two shift
  always_comb begin
    // R2 one plus code over six, in Q8
    low_num = (16'(s_reg.gain_code) + PGBL_LOW_BIAS) << 8;
    low_q = (low_num + (PGBL_LOW_DIV >> 1)) / PGBL_LOW_DIV;
    // R3 dB law turned into log2 in Q8
    lin_prod = 19'(s_reg.gain_code) * 19'(PGBL_LIN_SLOPE);
    lin_log = lin_prod[18:8];
    // R15 codes at or below the minimum give unity, never attenuation
    lin_pos = (lin_log > PGBL_LIN_OFFS) ? 11'(lin_log - PGBL_LIN_OFFS) : 11'h000;
    lut_k = lin_pos[7:4];
    lut_lo = lin_pos[3:0];
    lut_a = PGBL_EXP_LUT[lut_k];
    lut_b = PGBL_EXP_LUT[5'(lut_k) + 5'h01];
    // interpolation between table points keeps the curve smooth with a small table
    lut_step = 14'(lut_b - lut_a) * 14'(lut_lo);
    mant = PGBL_UNITY;
    gshift = 3'h0;
    unique case (VARIANT)
      PGBL_VAR_LOW: begin
        mant = low_q[11:0];
      end
      PGBL_VAR_WIDE_LINEAR: begin
        mant = 12'(lut_a) + 12'(lut_step >> 4);
        gshift = lin_pos[10:8];
      end
      default: begin
        // default gain law is not built here; unity keeps 0 dB at the lowest code
        mant = PGBL_UNITY;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // second stage arithmetic: apply shift, add offset, clamp
  always_comb begin
    scaled = 29'(s_reg.s1_prod) << s_reg.s1_shift;
    gained = scaled[28:8];
    // R16 saturate the gained value to the converter range
    gained12 = (gained > 21'(PGBL_MAX12)) ? PGBL_MAX12 : gained[11:0];
    base = s_reg.s1_depth8 ? (gained12 >> PGBL_DEPTH_SHIFT) : gained12;
    out_max = s_reg.s1_depth8 ? PGBL_MAX8 : PGBL_MAX12;
    // R4 offset rises with the black-level code
    sum = 13'(base) + 13'(s_reg.s1_offset);
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_next = s_reg;
    s_next.reject = 1'b0;
    if (GAIN_WR) begin
      // R13 R1 only an all-channels write in range is taken
      if (GAIN_SEL_ALL && (GAIN_CODE <= gain_max)) begin
        s_next.gain_code = GAIN_CODE;
      end else begin
        s_next.reject = 1'b1;
      end
    end
    if (BLACK_WR) begin
      // R14 R10 R11 R12 selector and range check
      if (BLACK_SEL_ALL && (BLACK_CODE <= black_max)) begin
        s_next.black_code = BLACK_CODE;
      end else begin
        s_next.reject = 1'b1;
      end
    end
    s_next.s1_valid = PIX_IN.valid;
    if (PIX_IN.valid) begin
      s_next.s1_prod = 24'(PIX_IN.data) * 24'(mant);
      s_next.s1_shift = gshift;
      s_next.s1_offset = s_reg.black_code >> bl_shift;
      s_next.s1_depth8 = (DEPTH == PGBL_DEPTH_8);
    end
    s_next.out.valid = s_reg.s1_valid;
    if (s_reg.s1_valid) begin
      // R16 clamp to the selected depth
      s_next.out.data = (sum > 13'(out_max)) ? out_max : sum[11:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s_reg <= '0;
      s_reg.gain_code <= PGBL_GAIN_RESET;
      s_reg.black_code <= PGBL_BLACK_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign PIX_OUT = s_reg.out;
  assign GAIN_NOW = s_reg.gain_code;
  assign BLACK_NOW = s_reg.black_code;
  assign CODE_REJECT = s_reg.reject;

endmodule

//--- pgbl_host.sv
// host software model that sets the gain and black-level codes
`timescale 1ns/1ps
module pgbl_host (
  input wire logic CLOCK,
  output logic GAIN_SEL_ALL,
  output logic GAIN_WR,
  output logic [9:0] GAIN_CODE,
  output logic BLACK_SEL_ALL,
  output logic BLACK_WR,
  output logic [9:0] BLACK_CODE
);
  initial begin
    {GAIN_SEL_ALL, GAIN_WR, BLACK_SEL_ALL, BLACK_WR} = 4'h0;
    {GAIN_CODE, BLACK_CODE} = 20'h0_0000;
  end
  task automatic put(input logic b, input logic [9:0] c, input logic s);
    @(negedge CLOCK);
    GAIN_SEL_ALL <= s & ~b;
    BLACK_SEL_ALL <= s & b;
    @(negedge CLOCK);
    GAIN_WR <= ~b;
    BLACK_WR <= b;
    {GAIN_CODE, BLACK_CODE} <= {c, c};
    @(negedge CLOCK);
    {GAIN_WR, BLACK_WR} <= 2'h0;
    // released codes turn over so a stale value never looks live
    {GAIN_CODE, BLACK_CODE} <= ~{c, c};
  endtask
endmodule

//--- pgbl_props.sv
// assertion checker for the pixel gain and black-level stage
`timescale 1ns/1ps
module pgbl_props (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire pgbl_pkg::pgbl_variant_t VARIANT,
  input wire pgbl_pkg::pgbl_depth_t DEPTH,
  input wire logic GAIN_SEL_ALL,
  input wire logic GAIN_WR,
  input wire logic [9:0] GAIN_CODE,
  input wire logic BLACK_SEL_ALL,
  input wire logic BLACK_WR,
  input wire logic [9:0] BLACK_CODE,
  input wire pgbl_pkg::pgbl_pix_t PIX_IN,
  input wire pgbl_pkg::pgbl_pix_t PIX_OUT,
  input wire logic [9:0] GAIN_NOW,
  input wire logic [9:0] BLACK_NOW,
  input wire logic CODE_REJECT
);
  import pgbl_pkg::*;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  property p_g1; VARIANT == PGBL_VAR_LOW && GAIN_WR && GAIN_CODE > 10'h016 |=> CODE_REJECT && $stable(GAIN_NOW);
  endproperty
  a_g1: assert property (p_g1) else $error("gain over range taken");
  property p_b10; VARIANT == PGBL_VAR_DEFAULT && BLACK_WR && BLACK_CODE > 10'h0FF |=> CODE_REJECT; endproperty
  a_b10: assert property (p_b10) else $error("black over range taken");
  property p_b11; VARIANT == PGBL_VAR_LOW && BLACK_WR && BLACK_CODE > 10'h040 |=> CODE_REJECT; endproperty
  a_b11: assert property (p_b11) else $error("black over range taken");
  property p_b12; VARIANT >= PGBL_VAR_WIDE_LOG && BLACK_WR && BLACK_SEL_ALL |=> BLACK_NOW == $past(BLACK_CODE);
  endproperty
  a_b12: assert property (p_b12) else $error("wide black code lost");
  property p_s13; GAIN_WR && !GAIN_SEL_ALL |=> CODE_REJECT && $stable(GAIN_NOW); endproperty
  a_s13: assert property (p_s13) else $error("gain taken without selector");
  property p_s14; BLACK_WR && !BLACK_SEL_ALL |=> CODE_REJECT && $stable(BLACK_NOW); endproperty
  a_s14: assert property (p_s14) else $error("black taken without selector");
  property p_u15; PIX_IN.valid && GAIN_NOW == 0 && BLACK_NOW == 0 && DEPTH == PGBL_DEPTH_12
    |-> ##2 PIX_OUT.valid && PIX_OUT.data == $past(PIX_IN.data, 2); endproperty
  a_u15: assert property (p_u15) else $error("zero code not unity");
  property p_c16; PIX_IN.valid && DEPTH == PGBL_DEPTH_8 |-> ##2 PIX_OUT.valid && PIX_OUT.data <= 12'h0FF;
  endproperty
  a_c16: assert property (p_c16) else $error("8 bit output out of range");
endmodule

//--- pgbl_core_tb_top.sv
// self-checking bench for the pixel gain and black-level stage
`timescale 1ns/1ps
module pgbl_core_tb_top;
  import pgbl_pkg::*;
  pgbl_variant_t vr = PGBL_VAR_LOW;
  pgbl_depth_t dp = PGBL_DEPTH_12;
  pgbl_pix_t pi = '0;
  pgbl_pix_t po;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rej, gs, gw, bs, bw;
  logic [9:0] gc, bc, gn, bn;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  initial forever #20 clk = ~clk;
  pgbl_host host_u (.CLOCK(clk), .GAIN_SEL_ALL(gs), .GAIN_WR(gw), .GAIN_CODE(gc), .BLACK_SEL_ALL(bs),
    .BLACK_WR(bw), .BLACK_CODE(bc));
  pgbl_core dut_u (.CLOCK(clk), .SYS_RST(rst), .VARIANT(vr), .DEPTH(dp), .GAIN_SEL_ALL(gs), .GAIN_WR(gw),
    .GAIN_CODE(gc), .BLACK_SEL_ALL(bs), .BLACK_WR(bw), .BLACK_CODE(bc), .PIX_IN(pi), .PIX_OUT(po),
    .GAIN_NOW(gn), .BLACK_NOW(bn), .CODE_REJECT(rej));
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic report_and_stop();
    if (fails == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic b, input logic [9:0] c, input logic s, input logic r, input logic [9:0] n);
    host_u.put(b, c, s);
    chk({11'h0, rej}, {11'h0, r});
    chk({2'h0, b ? bn : gn}, {2'h0, n});
  endtask
  task automatic px(input logic [11:0] d, input logic [11:0] e);
    @(negedge clk);
    pi <= '{valid: 1'b1, data: d};
    @(negedge clk);
    pi <= '{valid: 1'b0, data: ~d};
    // output stands one cycle: the edge after the input edge launches it
    @(negedge clk);
    chk({11'h0, po.valid}, 12'h001);
    chk(po.data, e);
  endtask
  task automatic bl(input pgbl_variant_t v, input pgbl_depth_t d, input logic [9:0] c, input logic [11:0] e);
    @(negedge clk);
    vr <= v;
    dp <= d;
    wr(1, c, 1, 0, c);
    px(12'h000, e);
  endtask
  task automatic t_low();
    wr(0, 10'h016, 1, 0, 10'h016);
    wr(0, 10'h017, 1, 1, 10'h016);
    px(12'h258, 12'hAF0);
    wr(0, 10'h000, 0, 1, 10'h016);
    wr(0, 10'h000, 1, 0, 10'h000);
    wr(1, 10'h041, 1, 1, 10'h000);
    wr(1, 10'h040, 1, 0, 10'h040);
    px(12'h000, 12'h010);
    wr(1, 10'h000, 0, 1, 10'h040);
  endtask
  task automatic t_black();
    bl(PGBL_VAR_DEFAULT, PGBL_DEPTH_8, 10'h0FF, 12'h00F);
    px(12'hFFF, 12'h0FF);
    bl(PGBL_VAR_DEFAULT, PGBL_DEPTH_12, 10'h0FF, 12'h0FF);
    bl(PGBL_VAR_WIDE_LOG, PGBL_DEPTH_8, 10'h3FF, 12'h00F);
    bl(PGBL_VAR_WIDE_LINEAR, PGBL_DEPTH_12, 10'h3FF, 12'h0FF);
    bl(PGBL_VAR_DEFAULT, PGBL_DEPTH_12, 10'h020, 12'h020);
    wr(1, 10'h100, 1, 1, 10'h020);
    px(12'hFFF, 12'hFFF);
  endtask
  task automatic t_lin();
    bl(PGBL_VAR_WIDE_LINEAR, PGBL_DEPTH_12, 10'h000, 12'h000);
    px(12'h123, 12'h123);
    wr(0, 10'h3FF, 1, 0, 10'h3FF);
    px(12'h00A, 12'h170);
  endtask
  task automatic t_rst();
    @(negedge clk);
    rst <= 1'b1;
    @(negedge clk);
    chk({po.valid, rej, gn}, 12'h000);
    chk({2'h0, bn}, 12'h000);
    rst <= 1'b0;
    px(12'h123, 12'h123);
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst <= 1'b0;
    t_low();
    t_black();
    t_lin();
    t_rst();
    report_and_stop();
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fails++;
      report_and_stop();
    end
  end
endmodule
bind pgbl_core pgbl_props chk_u (.*);
